// File: aovc_dimmer.sv
// duty-cycle dimmer for the point status indicator
// assumes level and span in the same units, span above zero
module aovc_dimmer
    import aovc_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // indicator carrier
    aovc_led_if.pwm   led
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        lit_q;
    wire  logic  wrap = ({1'b0, cnt_q} + {1'b0, PWM_STEP}) >= {1'b0, led.span};

    assign cnt_d   = wrap ? ZERO : cnt_q + PWM_STEP;
    assign led.lit = lit_q;

    // on-time over one sweep equals level / span
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= ZERO;
            lit_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lit_q <= cnt_q < led.level;
        end
    end

    property p_dim_dark;
        @(posedge clk_i) disable iff (rst_i)
        led.level == ZERO |=> !led.lit;
    endproperty
    a_dim_dark: assert property (p_dim_dark)
        else $error("indicator lit at zero output");
endmodule : aovc_dimmer

// File: aovc_led_if.sv
// carrier between the value control and the indicator dimmer
// assumes both ends run on the same clock
interface aovc_led_if;
    logic [15:0] level;
    logic [15:0] span;
    logic        lit;
    modport src (output level, output span, input lit);
    modport pwm (input level, input span, output lit);
endinterface : aovc_led_if

// File: aovc_pkg.sv
// constants, types and helpers of the analog output value control block
// assumes a single 25 MHz clock and a 32-bit classic Wishbone slave port
package aovc_pkg;
    localparam int          CLK_HZ      = 25_000_000;
    localparam int          SLOW_MS     = 250;
    localparam int          SLOW_CYC    = CLK_HZ / 1000 * SLOW_MS;
    localparam int          VAL_W       = 16;

    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_BKV     = 8'h04;
    localparam logic [7:0]  OFS_PV      = 8'h08;
    localparam logic [7:0]  OFS_TOOL    = 8'h0C;
    localparam logic [7:0]  OFS_STATUS  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_ST  = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MSK = 8'h18;

    localparam int          CTRL_TYPE   = 0;
    localparam int          CTRL_BK_LSB = 1;
    localparam int          TOOL_EN     = 16;
    localparam logic [2:0]  CTRL_RST    = 3'h0;
    localparam logic [15:0] BKV_RST     = 16'h0000;

    localparam int          NEV         = 4;
    localparam int          EV_RANGE    = 0;
    localparam int          EV_SUPPLY   = 1;
    localparam int          EV_BUS      = 2;
    localparam int          EV_UNREL    = 3;

    // millivolt / microamp figures
    localparam logic [15:0] V_MIN  = 16'h0000;
    localparam logic [15:0] V_MAX  = 16'h2710;
    localparam logic [15:0] V_UND  = 16'h0000;
    localparam logic [15:0] V_OVR  = 16'h2968;
    localparam logic [15:0] V_STEP = 16'h03E8;
    localparam logic [15:0] I_MIN  = 16'h0FA0;
    localparam logic [15:0] I_MAX  = 16'h4E20;
    localparam logic [15:0] I_UND  = 16'h0F50;
    localparam logic [15:0] I_OVR  = 16'h51E0;
    localparam logic [15:0] I_STEP = 16'h0640;
    localparam logic [15:0] ZERO   = 16'h0000;
    localparam logic [15:0] PWM_STEP = 16'h0064;

    typedef enum logic {
        VOLTAGE_SIGNAL_TYPE = 1'b0,
        CURRENT_SIGNAL_TYPE = 1'b1
    } aovc_sig_t;

    typedef enum logic [1:0] {
        BK_MIN   = 2'b00,
        BK_KEEP  = 2'b01,
        BK_VALUE = 2'b10
    } aovc_bk_t;

    function automatic logic [15:0] lim_min(input logic sig);
        lim_min = sig ? I_MIN : V_MIN;
    endfunction : lim_min

    function automatic logic [15:0] lim_max(input logic sig);
        lim_max = sig ? I_MAX : V_MAX;
    endfunction : lim_max

    function automatic logic [15:0] lim_step(input logic sig);
        lim_step = sig ? I_STEP : V_STEP;
    endfunction : lim_step

    function automatic logic in_range(input logic sig,
                                      input logic [15:0] v);
        in_range = sig ? (v >= I_UND && v <= I_OVR)
                       : (v >= V_UND && v <= V_OVR);
    endfunction : in_range
endpackage : aovc_pkg

// File: aovc_top.sv
// analog output point: value arbitration, override, backup, faults
// assumes synchronous button and supply inputs, classic Wishbone master
module aovc_top
    import aovc_pkg::*;
#(
    parameter int SLOW_CYCLES = aovc_pkg::SLOW_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // override buttons
    input  wire logic        btn_mid_i,
    input  wire logic        btn_plus_i,
    input  wire logic        btn_minus_i,
    // supervision
    input  wire logic        supply_ok_i,
    input  wire logic        supply_low_i,
    input  wire logic        bus_fail_i,
    // outputs
    output logic [15:0]      setpoint_o,
    output logic             sig_type_o,
    output logic             override_led_o,
    output logic             module_led_o,
    output logic             io_led_o,
    output logic             unreliable_o,
    output logic             irq_o
);
    import aovc_pkg::*;

    function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
        wb_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                wb_merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction : wb_merge

    logic            ack_q;
    logic [31:0]     rd_q;
    logic [2:0]      ctrl_q;
    logic [15:0]     bkv_q;
    logic [16:0]     tool_q;
    logic [NEV-1:0]  mask_q;
    logic [NEV-1:0]  stat_q;
    logic [NEV-1:0]  stat_d;
    logic            local_q;
    logic [15:0]     local_val_q;
    logic [15:0]     auto_q;
    logic            hold_zero_q;
    logic [15:0]     out_q;
    logic [15:0]     out_d;
    logic [31:0]     slow_cnt_q;
    logic            flash_q;
    logic            btn_mid_q;
    logic            btn_plus_q;
    logic            btn_minus_q;
    logic            bus_fail_q;
    logic            ovr_led_q;
    logic            mod_led_q;
    logic            unrel_q;
    logic            irq_q;

    aovc_led_if led_if ();

    aovc_dimmer u_dimmer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .led   (led_if.pwm)
    );

    // bus decode
    wire logic        req     = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic        wr      = req & wb_we_i;
    wire logic [7:0]  adr     = {wb_adr_i[7:2], 2'b00};
    wire logic        wr_ctrl = wr && adr == OFS_CTRL;
    wire logic        wr_bkv  = wr && adr == OFS_BKV;
    wire logic        wr_pv   = wr && adr == OFS_PV;
    wire logic        wr_tool = wr && adr == OFS_TOOL;
    wire logic        wr_ist  = wr && adr == OFS_IRQ_ST;
    wire logic        wr_msk  = wr && adr == OFS_IRQ_MSK;
    wire logic [31:0] wdat_ctrl = wb_merge({29'h0, ctrl_q}, wb_dat_i,
                                           wb_sel_i);
    wire logic [31:0] wdat_bkv  = wb_merge({16'h0, bkv_q}, wb_dat_i,
                                           wb_sel_i);
    wire logic [31:0] wdat_pv   = wb_merge(32'h0, wb_dat_i, wb_sel_i);
    wire logic [31:0] wdat_tool = wb_merge({15'h0, tool_q}, wb_dat_i,
                                           wb_sel_i);
    wire logic [31:0] wdat_ist  = wb_merge(32'h0, wb_dat_i, wb_sel_i);
    wire logic [31:0] wdat_msk  = wb_merge({28'h0, mask_q}, wb_dat_i,
                                           wb_sel_i);

    // point configuration
    wire logic        sig       = ctrl_q[CTRL_TYPE];
    wire aovc_bk_t    bk_mode   = aovc_bk_t'(ctrl_q[CTRL_BK_LSB +: 2]);
    wire logic        tool_en   = tool_q[TOOL_EN];
    wire logic [15:0] tool_val  = tool_q[15:0];
    wire logic [15:0] minv      = lim_min(sig);
    wire logic [15:0] maxv      = lim_max(sig);
    wire logic [15:0] step      = lim_step(sig);

    // status word
    wire logic [31:0] status_w  = {11'h0, local_q, tool_en, hold_zero_q,
                                   unrel_q, ~supply_ok_i, out_q};
    wire logic [31:0] rd_d =
        adr == OFS_CTRL    ? {29'h0, ctrl_q}  :
        adr == OFS_BKV     ? {16'h0, bkv_q}   :
        adr == OFS_TOOL    ? {15'h0, tool_q}  :
        adr == OFS_STATUS  ? status_w          :
        adr == OFS_IRQ_ST  ? {28'h0, stat_q}  :
        adr == OFS_IRQ_MSK ? {28'h0, mask_q}  : 32'h0;

    // faults and events
    wire logic sup_fail  = ~supply_ok_i;
    wire logic pv_ok     = wr_pv & in_range(sig, wdat_pv[15:0]);
    wire logic pv_bad    = wr_pv & ~pv_ok;
    wire logic bus_rise  = bus_fail_i & ~bus_fail_q;
    wire logic unrel_now = (sig == VOLTAGE_SIGNAL_TYPE) & supply_low_i;
    wire logic [NEV-1:0] ev = {unrel_now, bus_rise, sup_fail, pv_bad};

    // set wins over write-one-clear
    assign stat_d = ev | (stat_q & ~(wr_ist ? wdat_ist[NEV-1:0]
                                            : {NEV{1'b0}}));

    // buttons and slow tick
    wire logic slow_tick  = slow_cnt_q == 32'(SLOW_CYCLES - 1);
    wire logic mid_rise   = btn_mid_i & ~btn_mid_q;
    wire logic plus_step  = local_q & (btn_plus_i & (~btn_plus_q
                            | slow_tick));
    wire logic minus_step = local_q & (btn_minus_i & (~btn_minus_q
                            | slow_tick));

    // saturating steps, clamped to nominal span
    wire logic [16:0] up_sum = {1'b0, local_val_q} + {1'b0, step};
    wire logic [15:0] up_val = (up_sum > {1'b0, maxv}) ? maxv
                                                       : up_sum[15:0];
    wire logic [15:0] dn_val = (local_val_q < minv + step) ? minv
                               : local_val_q - step;

    wire logic [15:0] local_val_d =
        (mid_rise & ~local_q) ? out_q :
        (plus_step & ~minus_step) ? up_val :
        (minus_step & ~plus_step) ? dn_val : local_val_q;

    wire logic [15:0] bk_val =
        bk_mode == BK_KEEP  ? auto_q :
        bk_mode == BK_VALUE ? bkv_q  : minv;

    wire logic leave_local = mid_rise & local_q;
    wire logic [15:0] auto_d =
        sup_fail    ? ZERO :
        pv_ok       ? wdat_pv[15:0] :
        (leave_local & ~hold_zero_q) ? local_val_q :
        bus_rise    ? bk_val : auto_q;

    // supply failure forces zero over both overrides; override states stay untouched
    assign out_d = sup_fail ? ZERO :
                   local_q  ? local_val_q :
                   tool_en  ? tool_val    : auto_q;

    assign led_if.level = out_q;
    assign led_if.span  = maxv;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rd_q  <= 32'h0;
        end else begin
            ack_q <= req;
            rd_q  <= rd_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            bkv_q  <= BKV_RST;
            tool_q <= 17'h0;
            mask_q <= {NEV{1'b0}};
            stat_q <= {NEV{1'b0}};
            irq_q  <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_q <= wdat_ctrl[2:0];
            if (wr_bkv)  bkv_q  <= wdat_bkv[15:0];
            if (wr_tool) tool_q <= wdat_tool[16:0];
            if (wr_msk)  mask_q <= wdat_msk[NEV-1:0];
            stat_q <= stat_d;
            irq_q  <= |(stat_q & mask_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            local_q     <= 1'b0;
            local_val_q <= ZERO;
            auto_q      <= ZERO;
            hold_zero_q <= 1'b0;
            out_q       <= ZERO;
        end else begin
            if (mid_rise) local_q <= ~local_q;
            local_val_q <= local_val_d;
            auto_q      <= auto_d;
            if (sup_fail) hold_zero_q <= 1'b1;
            else if (pv_ok) hold_zero_q <= 1'b0;
            out_q <= out_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_cnt_q  <= 32'h0;
            flash_q     <= 1'b0;
            btn_mid_q   <= 1'b0;
            btn_plus_q  <= 1'b0;
            btn_minus_q <= 1'b0;
            bus_fail_q  <= 1'b0;
            ovr_led_q   <= 1'b0;
            mod_led_q   <= 1'b0;
            unrel_q     <= 1'b0;
        end else begin
            slow_cnt_q  <= slow_tick ? 32'h0 : slow_cnt_q + 32'h1;
            if (slow_tick) flash_q <= ~flash_q;
            btn_mid_q   <= btn_mid_i;
            btn_plus_q  <= btn_plus_i;
            btn_minus_q <= btn_minus_i;
            bus_fail_q  <= bus_fail_i;
            ovr_led_q   <= local_q;
            mod_led_q   <= tool_en & flash_q;
            unrel_q     <= unrel_now;
        end
    end

    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = rd_q;
    assign setpoint_o     = out_q;
    assign sig_type_o     = sig;
    assign override_led_o = ovr_led_q;
    assign module_led_o   = mod_led_q;
    assign io_led_o       = led_if.lit;
    assign unreliable_o   = unrel_q;
    assign irq_o          = irq_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_local_wins;
        local_q && !sup_fail |=> setpoint_o == $past(local_val_q);
    endproperty
    a_local_wins: assert property (p_local_wins)
        else $error("local override value not on output");

    property p_tool_next;
        !local_q && tool_en && !sup_fail |=> setpoint_o == $past(tool_val);
    endproperty
    a_tool_next: assert property (p_tool_next)
        else $error("tool override value not on output");

    property p_flash;
        !tool_en |=> !module_led_o;
    endproperty
    a_flash: assert property (p_flash)
        else $error("module indicator lit without tool override");

    property p_toggle;
        mid_rise |=> local_q != $past(local_q) ##1 override_led_o == local_q;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("centre button did not toggle local override");

    property p_plus;
        plus_step && !minus_step && !mid_rise && up_sum <= {1'b0, maxv}
        |=> local_val_q == $past(local_val_q) + $past(step);
    endproperty
    a_plus: assert property (p_plus)
        else $error("plus step wrong");

    property p_minus_sat;
        minus_step && !plus_step && !mid_rise && local_val_q == minv
        |=> local_val_q == $past(minv);
    endproperty
    a_minus_sat: assert property (p_minus_sat)
        else $error("minus step passed the minimum");

    property p_enter;
        mid_rise && !local_q |=> local_val_q == $past(out_q);
    endproperty
    a_enter: assert property (p_enter)
        else $error("entering local override changed the value");

    property p_leave;
        leave_local && !sup_fail && !pv_ok && !hold_zero_q
        |=> auto_q == $past(local_val_q);
    endproperty
    a_leave: assert property (p_leave)
        else $error("leaving local override lost the value");

    property p_range;
        pv_bad |=> stat_q[EV_RANGE] ##1 (irq_o || !mask_q[EV_RANGE]);
    endproperty
    a_range: assert property (p_range)
        else $error("range fault not reported");

    property p_supply;
        sup_fail |=> setpoint_o == ZERO && hold_zero_q;
    endproperty
    a_supply: assert property (p_supply)
        else $error("output not zero on supply failure");

    property p_backup;
        bus_rise && !sup_fail && !pv_ok && !leave_local && bk_mode == BK_MIN
        |=> auto_q == $past(minv);
    endproperty
    a_backup: assert property (p_backup)
        else $error("bus failure backup not applied");

    property p_unrel;
        sig == VOLTAGE_SIGNAL_TYPE && supply_low_i |=> unreliable_o;
    endproperty
    a_unrel: assert property (p_unrel)
        else $error("unreliable output not flagged");
endmodule : aovc_top

// File: aovc_wb_master.sv
// classic wishbone master model for the bus controller side
// assumes a slave that acks every request; bench timeout ends a hang
module aovc_wb_master (
    // clock
    input  wire logic        clk_i,
    // wishbone master side
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [31:0]      dat_o,
    output logic [3:0]       sel_o,
    input  wire logic        ack_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        dat_o = 32'h0;
        sel_o = 4'h0;
    end

    // one cycle held until ack, then a random idle gap
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] s = 4'hF);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= d;
        sel_o <= s;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        // released data stops showing the last word
        dat_o <= ~d;
        repeat ($urandom_range(0, 2)) @(posedge clk_i);
    endtask : xfer
endmodule : aovc_wb_master

// File: tb_top.sv
// self-checking bench of the analog output value control point
// assumes aovc_pkg, aovc_top and the master model compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aovc_pkg::*;

    localparam int          SLOW = 8;
    localparam logic [16:0] RV [7] = '{17'h02968, 17'h02969, 17'h00000,
        17'h10F50, 17'h10F4F, 17'h151E0, 17'h151E1};
    localparam logic [6:0]  RA = 7'h2D;

    logic        clk_i        = 1'b0;
    logic        rst_i        = 1'b1;
    logic        btn_mid_i    = 1'b0;
    logic        btn_plus_i   = 1'b0;
    logic        btn_minus_i  = 1'b0;
    logic        supply_ok_i  = 1'b1;
    logic        supply_low_i = 1'b0;
    logic        bus_fail_i   = 1'b0;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [15:0] setpoint_o;
    logic        sig_type_o;
    logic        override_led_o;
    logic        module_led_o;
    logic        io_led_o;
    logic        unreliable_o;
    logic        irq_o;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int          fails    = 0;
    int          n_checks = 0;
    int          ticks    = 0;

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    aovc_wb_master aovc_wb_master_inst (
        .clk_i (clk_i), .cyc_o (cyc), .stb_o (stb), .we_o (we),
        .adr_o (adr), .dat_o (wdat), .sel_o (sel), .ack_i (ack));

    aovc_top #(.SLOW_CYCLES(SLOW)) aovc_top_inst (
        .clk_i (clk_i), .rst_i (rst_i), .wb_cyc_i (cyc),
        .wb_stb_i (stb), .wb_we_i (we), .wb_adr_i (adr),
        .wb_dat_i (wdat), .wb_sel_i (sel), .wb_dat_o (rdat),
        .wb_ack_o (ack), .btn_mid_i (btn_mid_i),
        .btn_plus_i (btn_plus_i), .btn_minus_i (btn_minus_i),
        .supply_ok_i (supply_ok_i), .supply_low_i (supply_low_i),
        .bus_fail_i (bus_fail_i), .setpoint_o (setpoint_o),
        .sig_type_o (sig_type_o), .override_led_o (override_led_o),
        .module_led_o (module_led_o), .io_led_o (io_led_o),
        .unreliable_o (unreliable_o), .irq_o (irq_o));

    task automatic tally_and_finish;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // read results are compared here against the oldest note
    always @(posedge clk_i) begin
        ticks <= ticks + 1;
        if (ack === 1'b1 && we === 1'b0) begin
            chk(rdat & msk_q.pop_front(), exp_q.pop_front());
        end
        if (ticks == 30000) begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aovc_wb_master_inst.xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        aovc_wb_master_inst.xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic sp(input logic [15:0] v);
        idle(3);
        rd(OFS_STATUS, {16'h0, v}, 32'h0000FFFF);
    endtask : sp

    task automatic push(input int b, input int n);
        @(posedge clk_i);
        case (b)
            0: btn_mid_i <= 1'b1;
            1: btn_plus_i <= 1'b1;
            default: btn_minus_i <= 1'b1;
        endcase
        idle(n);
        btn_mid_i <= 1'b0;
        btn_plus_i <= 1'b0;
        btn_minus_i <= 1'b0;
        idle(3);
    endtask : push

    task automatic sup(input logic ok);
        @(posedge clk_i);
        supply_ok_i <= ok;
        idle(4);
    endtask : sup

    task automatic watch(input int n, output int hi, output int tg);
        logic prev;
        hi = 0;
        tg = 0;
        prev = module_led_o;
        repeat (n) begin
            @(posedge clk_i);
            hi += (io_led_o === 1'b1);
            tg += (module_led_o !== prev);
            prev = module_led_o;
        end
    endtask : watch

    initial begin
        int          hi;
        int          tg;
        logic [15:0] v;
        logic [15:0] last;
        void'($urandom(32'hEC1675AC));
        idle(6);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFS_CTRL, 32'h0, 32'h7);
        rd(OFS_STATUS, 32'h0, 32'hFFFFFFFF);
        rd(OFS_BKV, 32'h0, 32'hFFFF);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF);
        last = 16'h0;
        for (int k = 0; k < 7; k++) begin
            v = (k == 2) ? 16'($urandom_range(0, 10600)) : RV[k][15:0];
            wr(OFS_CTRL, {31'h0, RV[k][16]});
            wr(OFS_IRQ_ST, 32'hF);
            wr(OFS_PV, {16'h0, v});
            if (RA[k]) begin
                last = v;
            end
            chk(sig_type_o, RV[k][16]);
            sp(last);
            rd(OFS_IRQ_ST, {31'h0, ~RA[k]}, 32'h1);
        end
        wr(OFS_IRQ_ST, 32'hF);
        wr(OFS_PV, 32'hFFFF);
        idle(3);
        chk(irq_o, 0);
        wr(OFS_IRQ_MSK, 32'h1);
        idle(3);
        chk(irq_o, 1);
        wr(OFS_IRQ_ST, 32'h1);
        idle(3);
        chk(irq_o, 0);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_PV, 32'h1388);
        watch(64, hi, tg);
        chk(tg, 0);
        wr(OFS_TOOL, 32'h10BB8);
        wr(OFS_PV, 32'h1770);
        sp(16'h0BB8);
        watch(64, hi, tg);
        chk(tg > 6 && tg < 10, 1);
        push(0, 1);
        chk(override_led_o, 1);
        sp(16'h0BB8);
        push(1, 1);
        sp(16'h0FA0);
        push(2, 1);
        sp(16'h0BB8);
        push(1, 120);
        sp(16'h2710);
        watch(200, hi, tg);
        chk(hi > 195, 1);
        push(2, 120);
        sp(16'h0000);
        watch(200, hi, tg);
        chk(hi, 0);
        repeat (5) push(1, 1);
        sp(16'h1388);
        watch(200, hi, tg);
        chk(hi > 94 && hi < 106, 1);
        wr(OFS_TOOL, 32'h0);
        push(0, 1);
        chk(override_led_o, 0);
        sp(16'h1388);
        wr(OFS_PV, 32'h07D0);
        sp(16'h07D0);
        sup(1'b0);
        chk(setpoint_o, 0);
        rd(OFS_STATUS, 32'h10000, 32'h10000);
        sup(1'b1);
        rd(OFS_STATUS, 32'h40000, 32'h7FFFF);
        wr(OFS_PV, 32'h07D0);
        sp(16'h07D0);
        push(0, 1);
        sup(1'b0);
        chk(setpoint_o, 0);
        sup(1'b1);
        chk(setpoint_o, 32'h07D0);
        push(0, 1);
        for (int m = 0; m < 5; m++) begin
            wr(OFS_BKV, 32'h1B58);
            wr(OFS_CTRL, (m == 4) ? 32'h1 : 32'(m << 1));
            wr(OFS_PV, 32'h1388);
            wr(OFS_IRQ_ST, 32'hF);
            @(posedge clk_i);
            bus_fail_i <= 1'b1;
            v = (m == 1) ? 16'h1388 : (m == 2) ? 16'h1B58 :
                (m == 4) ? 16'h0FA0 : 16'h0000;
            sp(v);
            rd(OFS_IRQ_ST, 32'h4, 32'h4);
            @(posedge clk_i);
            bus_fail_i <= 1'b0;
        end
        aovc_wb_master_inst.xfer(1'b1, OFS_BKV, 32'hFFFFFF34, 4'h1);
        rd(OFS_BKV, 32'h1B34, 32'hFFFF);
        wr(OFS_CTRL, 32'h0);
        @(posedge clk_i);
        supply_low_i <= 1'b1;
        idle(3);
        chk(unreliable_o, 1);
        rd(OFS_IRQ_ST, 32'h8, 32'h8);
        wr(OFS_CTRL, 32'h1);
        idle(3);
        chk(unreliable_o, 0);
        supply_low_i <= 1'b0;
        idle(5);
        tally_and_finish();
    end
endmodule : tb_top
